// File: pkg/incmc_consts.svh
// Constants for the increment memory controller.
// Assumes inclusion by the package and design files by bare name.
`ifndef INCMC_CONSTS_SVH
`define INCMC_CONSTS_SVH
`define INCMC_ADDR_W        15
`define INCMC_DEV_CODE      6'h2a
`define INCMC_SUB_SET_TICK  2'h0
`define INCMC_SUB_FLAG      2'h1
`define INCMC_SUB_TICK_OFF  2'h2
`define INCMC_ADDR_RESET    15'h0018
`define INCMC_TRAP_RESET    15'h0024
`define INCMC_TICK_RESET    16'h0064
`define INCMC_STAT_ENA_BIT  1
`define INCMC_STAT_FLAG_BIT 0
`define INCMC_STAT_BUSY_BIT 2
`define INCMC_OFS_CTRL      16'h0000
`define INCMC_OFS_DIV       16'h0004
`define INCMC_OFS_TRAP      16'h0008
`define INCMC_OFS_STAT      16'h000c
`endif

// File: pkg/incmc_pkg.sv
// Types for the increment memory controller.
// Assumes the constants header is on the include path.
`include "incmc_consts.svh"
package incmc_pkg;
   typedef enum logic [3:0] {
      INCMC_IDLE   = 4'b0001,
      INCMC_ARMED  = 4'b0010,
      INCMC_REQ    = 4'b0100,
      INCMC_ACTIVE = 4'b1000
   } incmc_state_t;
   typedef logic [`INCMC_ADDR_W-1:0] incmc_addr_t;
endpackage

// File: pkg/incmc_sync_if.sv
// Carrier for synchronised bus inputs between synchroniser and controller.
// Assumes a single core_clk domain.
`timescale 1ns/1ps
interface incmc_sync_if;
   logic sync_rise;
   logic ch_grant;
   logic ch_prio_en;
   logic l0_chain_en;
   logic l0_grant;
   logic ovf_rise;
   logic clear_rise;
   logic iot_rise;
   logic rd_status;
   logic [5:0] dev_sel;
   logic [1:0] sub_sel;
   modport src (output sync_rise, ch_grant, ch_prio_en, l0_chain_en,
                l0_grant, ovf_rise, clear_rise, iot_rise, rd_status,
                dev_sel, sub_sel);
   modport dst (input sync_rise, ch_grant, ch_prio_en, l0_chain_en,
                l0_grant, ovf_rise, clear_rise, iot_rise, rd_status,
                dev_sel, sub_sel);
endinterface

// File: design/incmc_sync.sv
// Two-flop synchronisers and edge detectors for the I/O bus inputs.
// Assumes all pins are asynchronous to core_clk.
`timescale 1ns/1ps
module incmc_sync
   import incmc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       bus_sync_pulse,
   input  wire logic       channel_grant,
   input  wire logic       channel_priority_enable,
   input  wire logic       level0_chain_enable,
   input  wire logic       level0_priority_grant,
   input  wire logic       increment_overflow_pulse,
   input  wire logic       bus_system_clear,
   input  wire logic       first_iot_pulse,
   input  wire logic       read_status_instruction,
   input  wire logic [5:0] device_select_lines,
   input  wire logic [1:0] subdevice_select_lines,
   incmc_sync_if.src       sb
);
   logic [16:0] meta;
   logic [16:0] stable;
   logic [3:0]  prev;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta   <= 17'h0;
         stable <= 17'h0;
      end else begin
         meta   <= {bus_sync_pulse, channel_grant, channel_priority_enable,
                    level0_chain_enable, level0_priority_grant,
                    increment_overflow_pulse, bus_system_clear,
                    first_iot_pulse, read_status_instruction,
                    device_select_lines, subdevice_select_lines};
         stable <= meta;
      end
   end
   // Edge history taken from the second stage only
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prev <= 4'h0;
      end else begin
         prev <= {stable[16], stable[11], stable[10], stable[9]};
      end
   end
   assign sb.sync_rise   = stable[16] & ~prev[3];
   assign sb.ch_grant    = stable[15];
   assign sb.ch_prio_en  = stable[14];
   assign sb.l0_chain_en = stable[13];
   assign sb.l0_grant    = stable[12];
   assign sb.ovf_rise    = stable[11] & ~prev[2];
   assign sb.clear_rise  = stable[10] & ~prev[1];
   assign sb.iot_rise    = stable[9] & ~prev[0];
   assign sb.rd_status   = stable[8];
   assign sb.dev_sel     = stable[7:2];
   assign sb.sub_sel     = stable[1:0];
endmodule

// File: design/incmc_top.sv
// Increment memory controller on the I/O bus, device side.
// Assumes bus pins asynchronous to core_clk; active-low lines as plain bits.
// Contract
// - Program enable starts the tick source.
// - Channel request sets on next sync.
// - Request line, grant sets channel active.
// - Active drives address and increment line.
// - Overflow sets flag, raises level0 or interrupt.
// - No data lines driven, no data register.
// - Channel request needs enable; block downstream.
// - Level0 request needs enable; cut downstream.
// - Device sets its own level0 request.
// - Skip returned on first pulse when true.
// - Status strobe gates one bit per line.
// - Skip tests flag; clear drops flag and request.
// - Decode device and subdevice select code.
// - Level0 grant drives trap address.
// - System clear initialises all state.
`timescale 1ns/1ps
`include "incmc_consts.svh"
module incmc_top
   import incmc_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     nrst,
   input  wire logic                     bus_sync_pulse,
   input  wire logic                     channel_grant,
   input  wire logic                     channel_priority_enable,
   input  wire logic                     level0_chain_enable,
   input  wire logic                     level0_priority_grant,
   input  wire logic                     increment_overflow_pulse,
   input  wire logic                     bus_system_clear,
   input  wire logic                     first_iot_pulse,
   input  wire logic                     read_status_instruction,
   input  wire logic [5:0]               device_select_lines,
   input  wire logic [1:0]               subdevice_select_lines,
   input  wire logic [`INCMC_ADDR_W-1:0] count_address,
   input  wire logic                     api_select,
   input  wire logic [15:0]              regs_addr,
   input  wire logic [31:0]              regs_wdata,
   input  wire logic                     regs_write,
   input  wire logic                     regs_read,
   output logic      [31:0]              regs_rdata,
   output logic                          channel_request_line_n,
   output logic                          increment_memory_line_n,
   output logic      [`INCMC_ADDR_W-1:0] bus_address_out,
   output logic                          bus_address_oe,
   output logic                          level0_priority_request_n,
   output logic                          program_interrupt_request_n,
   output logic                          skip_request_n,
   output logic      [17:0]              status_lines_out,
   output logic                          status_lines_oe,
   output logic                          channel_priority_enable_out,
   output logic                          level0_chain_enable_out
);
   localparam logic [15:0] OFS_CTRL  = `INCMC_OFS_CTRL;
   localparam logic [15:0] OFS_DIV   = `INCMC_OFS_DIV;
   localparam logic [15:0] OFS_TRAP  = `INCMC_OFS_TRAP;
   localparam logic [15:0] OFS_STAT  = `INCMC_OFS_STAT;

   incmc_sync_if sb ();

   incmc_sync u_sync (
      .core_clk                 (core_clk),
      .nrst                     (nrst),
      .bus_sync_pulse           (bus_sync_pulse),
      .channel_grant            (channel_grant),
      .channel_priority_enable  (channel_priority_enable),
      .level0_chain_enable      (level0_chain_enable),
      .level0_priority_grant    (level0_priority_grant),
      .increment_overflow_pulse (increment_overflow_pulse),
      .bus_system_clear         (bus_system_clear),
      .first_iot_pulse          (first_iot_pulse),
      .read_status_instruction  (read_status_instruction),
      .device_select_lines      (device_select_lines),
      .subdevice_select_lines   (subdevice_select_lines),
      .sb                       (sb)
   );

   incmc_state_t state;
   logic         count_enable_flag;
   logic         tick_request_flag;
   logic         overflow_flag;
   logic         prio_pending;
   logic [15:0]  tick_div;
   logic [15:0]  tick_cnt;
   logic [`INCMC_ADDR_W-1:0] trap_addr;
   logic         selected;
   logic         sw_set_tick;
   logic         sw_clr_tick;
   logic         iot_set;
   logic         iot_clear;
   logic         iot_skip;
   logic         clear_all;
   logic         tick_fire;
   logic         api_ok;

   function automatic logic dev_hit(input logic [5:0] sel);
      dev_hit = (sel == `INCMC_DEV_CODE);
   endfunction

   assign clear_all = sb.clear_rise;
   assign selected  = dev_hit(sb.dev_sel);
   assign iot_set   = sb.iot_rise & selected
                      & (sb.sub_sel == `INCMC_SUB_SET_TICK);
   assign iot_skip  = sb.iot_rise & selected
                      & (sb.sub_sel == `INCMC_SUB_FLAG);
   assign iot_clear = sb.iot_rise & selected
                      & (sb.sub_sel == `INCMC_SUB_TICK_OFF);
   assign sw_set_tick = regs_write & (regs_addr == OFS_CTRL)
                        & regs_wdata[0];
   assign sw_clr_tick = regs_write & (regs_addr == OFS_CTRL)
                        & ~regs_wdata[0];
   assign api_ok = api_select & sb.l0_chain_en;

   // Count enable flag and tick source
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count_enable_flag <= 1'b0;
      end else if (clear_all) begin
         count_enable_flag <= 1'b0;
      end else if (iot_set || sw_set_tick) begin
         count_enable_flag <= 1'b1;
      end else if (sw_clr_tick) begin
         count_enable_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 16'h0;
      end else if (clear_all || !count_enable_flag) begin
         tick_cnt <= 16'h0;
      end else if (tick_cnt >= tick_div) begin
         tick_cnt <= 16'h0;
      end else begin
         tick_cnt <= tick_cnt + 16'h1;
      end
   end
   assign tick_fire = count_enable_flag && (tick_cnt >= tick_div);

   // Divider and trap address registers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tick_div  <= `INCMC_TICK_RESET;
         trap_addr <= `INCMC_TRAP_RESET;
      end else if (clear_all) begin
         tick_div  <= `INCMC_TICK_RESET;
         trap_addr <= `INCMC_TRAP_RESET;
      end else if (regs_write && regs_addr == OFS_DIV) begin
         tick_div  <= regs_wdata[15:0];
      end else if (regs_write && regs_addr == OFS_TRAP) begin
         trap_addr <= regs_wdata[`INCMC_ADDR_W-1:0];
      end
   end

   // Tick request flag; a new tick wins over the end-of-cycle clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tick_request_flag <= 1'b0;
      end else if (clear_all) begin
         tick_request_flag <= 1'b0;
      end else if (tick_fire) begin
         tick_request_flag <= 1'b1;
      end else if (state == INCMC_ACTIVE && !sb.ch_grant) begin
         tick_request_flag <= 1'b0;
      end
   end

   // Channel request sequence
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state <= INCMC_IDLE;
      end else if (clear_all) begin
         state <= INCMC_IDLE;
      end else begin
         case (state)
            INCMC_IDLE: begin
               if (tick_request_flag) begin
                  state <= INCMC_ARMED;
               end
            end
            INCMC_ARMED: begin
               // Wait for sync with the chain enable present
               if (sb.sync_rise && sb.ch_prio_en) begin
                  state <= INCMC_REQ;
               end
            end
            INCMC_REQ: begin
               if (sb.ch_grant) begin
                  state <= INCMC_ACTIVE;
               end
            end
            INCMC_ACTIVE: begin
               if (!sb.ch_grant) begin
                  state <= INCMC_IDLE;
               end
            end
            default: begin
               state <= INCMC_IDLE;
            end
         endcase
      end
   end

   // Overflow flag and pending level0 request; set wins over clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
      end else if (clear_all) begin
         overflow_flag <= 1'b0;
      end else if (sb.ovf_rise && state == INCMC_ACTIVE) begin
         overflow_flag <= 1'b1;
      end else if (iot_clear) begin
         overflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prio_pending <= 1'b0;
      end else if (clear_all) begin
         prio_pending <= 1'b0;
      end else if (sb.ovf_rise && state == INCMC_ACTIVE && api_select) begin
         prio_pending <= 1'b1;
      end else if (iot_clear || (prio_pending && sb.l0_grant)) begin
         prio_pending <= 1'b0;
      end
   end

   // Bus outputs, active-low request lines
   always_comb begin
      channel_request_line_n  = ~(state == INCMC_REQ);
      increment_memory_line_n = ~(state == INCMC_ACTIVE);
      channel_priority_enable_out = sb.ch_prio_en
                                    & ~(state == INCMC_REQ);
      level0_priority_request_n = ~(prio_pending & api_ok);
      level0_chain_enable_out = sb.l0_chain_en
                                & ~(prio_pending & api_select);
      program_interrupt_request_n = ~(overflow_flag & ~api_select);
      skip_request_n = ~(iot_skip & overflow_flag);
      // Address only; data lines never driven
      bus_address_oe  = (state == INCMC_ACTIVE)
                        | (prio_pending & sb.l0_grant);
      if (state == INCMC_ACTIVE) begin
         bus_address_out = count_address;
      end else if (prio_pending && sb.l0_grant) begin
         bus_address_out = trap_addr;
      end else begin
         bus_address_out = '0;
      end
      status_lines_oe  = sb.rd_status;
      status_lines_out = 18'h0;
      status_lines_out[`INCMC_STAT_FLAG_BIT] = overflow_flag;
      status_lines_out[`INCMC_STAT_ENA_BIT]  = count_enable_flag;
      status_lines_out[`INCMC_STAT_BUSY_BIT] = (state != INCMC_IDLE);
   end

   // Register read port, data one cycle after strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         regs_rdata <= 32'h0;
      end else if (regs_read) begin
         case (regs_addr)
            OFS_CTRL: regs_rdata <= {31'h0, count_enable_flag};
            OFS_DIV:  regs_rdata <= {16'h0, tick_div};
            OFS_TRAP: regs_rdata <= {17'h0, trap_addr};
            OFS_STAT: regs_rdata <= {26'h0, state, prio_pending,
                                     overflow_flag};
            default:  regs_rdata <= 32'h0;
         endcase
      end else begin
         regs_rdata <= 32'h0;
      end
   end
endmodule

// File: verif/incmc_props.sv
// Port checker for the increment memory controller.
// Assumes binding to incmc_top, one core_clk domain.
`timescale 1ns/1ps
module incmc_props (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        bus_sync_pulse,
   input wire logic        channel_grant,
   input wire logic [14:0] count_address,
   input wire logic        channel_request_line_n,
   input wire logic        increment_memory_line_n,
   input wire logic [14:0] bus_address_out,
   input wire logic        bus_address_oe,
   input wire logic        level0_priority_request_n,
   input wire logic        program_interrupt_request_n,
   input wire logic        skip_request_n,
   input wire logic        channel_priority_enable_out,
   input wire logic        level0_chain_enable_out
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence s_start;
      $fell(increment_memory_line_n) ##0 bus_address_oe;
   endsequence
   sequence s_release;
      ##[1:8] (increment_memory_line_n && channel_request_line_n);
   endsequence
   a_chain_block: assert property (
      !channel_request_line_n |-> !channel_priority_enable_out)
      else $error("Channel chain not blocked");
   a_l0_cut: assert property (
      !level0_priority_request_n |-> !level0_chain_enable_out)
      else $error("Level0 chain not cut");
   a_addr_drive: assert property (
      !increment_memory_line_n |->
      bus_address_oe && bus_address_out == count_address)
      else $error("Count address not driven");
   a_grant_start: assert property (
      s_start |-> $past(channel_grant))
      else $error("Active without grant");
   a_sync_req: assert property (
      $fell(channel_request_line_n) |-> bus_sync_pulse)
      else $error("Request off sync");
   a_cycle_end: assert property (
      $fell(channel_grant) |-> s_release)
      else $error("Cycle not released");
   a_skip_pulse: assert property (
      !skip_request_n |=> skip_request_n)
      else $error("Skip held too long");
   a_one_report: assert property (
      !level0_priority_request_n |-> program_interrupt_request_n)
      else $error("Both reports raised");
endmodule
bind incmc_top incmc_props u_props (.core_clk, .nrst, .bus_sync_pulse,
   .channel_grant, .count_address, .channel_request_line_n,
   .increment_memory_line_n, .bus_address_out, .bus_address_oe,
   .level0_priority_request_n, .program_interrupt_request_n,
   .skip_request_n, .channel_priority_enable_out, .level0_chain_enable_out);

// File: verif/incmc_iop_model.sv
// I/O processor model: sync pulse, channel grant, memory increment.
// Assumes one memory word and a bench-set grant delay.
`timescale 1ns/1ps
module incmc_iop_model (
   input  wire logic        core_clk,
   input  wire logic        req_n,
   input  wire logic        inc_n,
   input  wire logic [14:0] addr,
   input  wire logic [3:0]  gdly,
   output logic             sync,
   output logic             grant,
   output logic             ovf
);
   logic [6:0]  scnt = 7'h0;
   logic [17:0] mem_word = 18'h0;
   logic [14:0] seen = 15'h0;
   int          incs = 0;
   initial sync = 0;
   always @(posedge core_clk) begin
      scnt <= (scnt == 7'd124) ? 7'h0 : scnt + 7'h1;
      sync <= (scnt < 7'd31);
   end
   initial begin
      grant = 0;
      ovf = 0;
      forever begin
         @(posedge core_clk);
         if (req_n === 1'b0) begin
            repeat (gdly) @(posedge core_clk);
            grant <= 1;
            while (inc_n !== 1'b0) @(posedge core_clk);
            seen = addr;
            mem_word = mem_word + 18'h1;
            incs++;
            if (mem_word == 18'h0) begin
               ovf <= 1;
               repeat (4) @(posedge core_clk);
               ovf <= 0;
            end
            repeat (4) @(posedge core_clk);
            grant <= 0;
            while (inc_n !== 1'b1) @(posedge core_clk);
            repeat (2) @(posedge core_clk);
         end
      end
   end
endmodule

// File: verif/tb_top.sv
// Testbench for the increment memory controller.
// Assumes the I/O processor model and the bound checker.
`timescale 1ns/1ps
`include "incmc_consts.svh"
module tb_top;
   logic        core_clk, nrst, bus_sync_pulse, channel_grant;
   logic        channel_priority_enable, level0_chain_enable;
   logic        level0_priority_grant, increment_overflow_pulse;
   logic        bus_system_clear, first_iot_pulse, read_status_instruction;
   logic [5:0]  device_select_lines;
   logic [1:0]  subdevice_select_lines;
   logic [14:0] count_address, bus_address_out;
   logic        api_select, regs_write, regs_read, status_lines_oe;
   logic [15:0] regs_addr;
   logic [31:0] regs_wdata, regs_rdata;
   logic        channel_request_line_n, increment_memory_line_n;
   logic        bus_address_oe, level0_priority_request_n, skip_request_n;
   logic        program_interrupt_request_n, channel_priority_enable_out;
   logic        level0_chain_enable_out;
   logic [17:0] status_lines_out;
   logic [3:0]  gdly;
   int          failures = 0, tests_run = 0, cyc = 0;
   incmc_top DUT (.core_clk, .nrst, .bus_sync_pulse, .channel_grant,
      .channel_priority_enable, .level0_chain_enable, .level0_priority_grant,
      .increment_overflow_pulse, .bus_system_clear, .first_iot_pulse,
      .read_status_instruction, .device_select_lines,
      .subdevice_select_lines, .count_address, .api_select, .regs_addr,
      .regs_wdata, .regs_write, .regs_read, .regs_rdata,
      .channel_request_line_n, .increment_memory_line_n, .bus_address_out,
      .bus_address_oe, .level0_priority_request_n,
      .program_interrupt_request_n, .skip_request_n, .status_lines_out,
      .status_lines_oe, .channel_priority_enable_out,
      .level0_chain_enable_out);
   incmc_iop_model iop (.core_clk, .req_n(channel_request_line_n),
      .inc_n(increment_memory_line_n), .addr(bus_address_out), .gdly,
      .sync(bus_sync_pulse), .grant(channel_grant),
      .ovf(increment_overflow_pulse));
   initial begin
      core_clk = 0;
      forever #4 core_clk = ~core_clk;
   end
   task wrap_up;
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         $display("BAD %0t timeout", $time);
         wrap_up;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regs_addr <= a;
      regs_wdata <= d;
      regs_write <= 1;
      @(posedge core_clk);
      regs_write <= 0;
   endtask
   task rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regs_addr <= a;
      regs_read <= 1;
      @(posedge core_clk);
      regs_read <= 0;
      #1 d = regs_rdata;
   endtask
   task io_transfer_instruction(input logic [5:0] dv, input logic [1:0] sb, output logic sk);
      sk = 0;
      @(posedge core_clk);
      device_select_lines <= dv;
      subdevice_select_lines <= sb;
      first_iot_pulse <= 1;
      repeat (8) begin
         @(posedge core_clk);
         #1 if (skip_request_n === 1'b0) sk = 1;
      end
      @(posedge core_clk);
      first_iot_pulse <= 0;
   endtask
   task t_reset;
      logic [31:0] d;
      rd(16'h4, d);
      chk(d, 32'(`INCMC_TICK_RESET));
      rd(16'h8, d);
      chk(d, 32'(`INCMC_TRAP_RESET));
      rd(16'hc, d);
      chk(d, 32'h4);
      rd(16'h10, d);
      chk(d, 32'h0);
      repeat (300) @(posedge core_clk);
      chk(iop.incs, 0);
      $display("t_reset end");
   endtask
   task t_count;
      int n;
      count_address <= 15'h0123;
      iop.mem_word = 18'h5;
      wr(16'h0, 32'h1);
      while (iop.incs < 3) @(posedge core_clk);
      chk(32'(iop.seen), 32'h0123);
      chk(32'(iop.mem_word), 32'h8);
      wr(16'h0, 32'h0);
      repeat (300) @(posedge core_clk);
      n = iop.incs;
      repeat (600) @(posedge core_clk);
      chk(iop.incs, n);
      $display("t_count end");
   endtask
   task t_flag;
      logic sk;
      logic hit;
      logic [31:0] d;
      api_select <= 1;
      level0_chain_enable <= 0;
      iop.mem_word = 18'h3ffff;
      io_transfer_instruction(`INCMC_DEV_CODE, `INCMC_SUB_SET_TICK, sk);
      while (iop.mem_word != 18'h0) @(posedge core_clk);
      wr(16'h0, 32'h0);
      repeat (300) @(posedge core_clk);
      chk(32'(level0_priority_request_n), 32'h1);
      level0_chain_enable <= 1;
      repeat (6) @(posedge core_clk);
      chk(32'(level0_priority_request_n), 32'h0);
      chk(32'(program_interrupt_request_n), 32'h1);
      io_transfer_instruction(`INCMC_DEV_CODE ^ 6'h01, `INCMC_SUB_FLAG, sk);
      chk(32'(sk), 32'h0);
      io_transfer_instruction(`INCMC_DEV_CODE, `INCMC_SUB_FLAG, sk);
      chk(32'(sk), 32'h1);
      read_status_instruction <= 1;
      repeat (6) @(posedge core_clk);
      chk(32'(status_lines_oe), 32'h1);
      chk(32'(status_lines_out[`INCMC_STAT_FLAG_BIT]), 32'h1);
      chk(32'(status_lines_out[`INCMC_STAT_ENA_BIT]), 32'h0);
      chk(32'(status_lines_out[`INCMC_STAT_BUSY_BIT]), 32'h0);
      read_status_instruction <= 0;
      wr(16'h8, 32'h0044);
      level0_priority_grant <= 1;
      hit = 0;
      // Trap address stands only in the cycle the grant is first seen
      repeat (6) begin
         @(posedge core_clk);
         #1 if (bus_address_oe && bus_address_out == 15'h0044) hit = 1;
      end
      chk(32'(hit), 32'h1);
      @(posedge core_clk);
      level0_priority_grant <= 0;
      repeat (6) @(posedge core_clk);
      chk(32'(level0_priority_request_n), 32'h1);
      io_transfer_instruction(`INCMC_DEV_CODE, `INCMC_SUB_TICK_OFF, sk);
      io_transfer_instruction(`INCMC_DEV_CODE, `INCMC_SUB_FLAG, sk);
      chk(32'(sk), 32'h0);
      rd(16'hc, d);
      chk(32'(d[0]), 32'h0);
      $display("t_flag end");
   endtask
   task t_pi;
      logic sk;
      logic [31:0] d;
      api_select <= 0;
      iop.mem_word = 18'h3ffff;
      wr(16'h4, 32'h30);
      wr(16'h0, 32'h1);
      while (program_interrupt_request_n !== 1'b0) @(posedge core_clk);
      wr(16'h0, 32'h0);
      chk(32'(level0_priority_request_n), 32'h1);
      // Trap routine at location zero polls the skip chain
      io_transfer_instruction(`INCMC_DEV_CODE, `INCMC_SUB_FLAG, sk);
      chk(32'(sk), 32'h1);
      repeat (300) @(posedge core_clk);
      bus_system_clear <= 1;
      repeat (4) @(posedge core_clk);
      bus_system_clear <= 0;
      repeat (6) @(posedge core_clk);
      chk(32'(program_interrupt_request_n), 32'h1);
      rd(16'h4, d);
      chk(d, 32'(`INCMC_TICK_RESET));
      rd(16'h8, d);
      chk(d, 32'(`INCMC_TRAP_RESET));
      $display("t_pi end");
   endtask
   task t_chain;
      int n;
      gdly <= 4'd9;
      channel_priority_enable <= 0;
      n = iop.incs;
      wr(16'h0, 32'h1);
      repeat (500) @(posedge core_clk);
      chk(iop.incs, n);
      chk(32'(channel_request_line_n), 32'h1);
      chk(32'(channel_priority_enable_out), 32'h0);
      channel_priority_enable <= 1;
      while (iop.incs == n) @(posedge core_clk);
      wr(16'h0, 32'h0);
      repeat (300) @(posedge core_clk);
      nrst <= 0;
      repeat (2) @(posedge core_clk);
      chk(32'(bus_address_oe), 32'h0);
      nrst <= 1;
      $display("t_chain end");
   endtask
   initial begin
      nrst = 0;
      channel_priority_enable = 1;
      level0_chain_enable = 1;
      level0_priority_grant = 0;
      bus_system_clear = 0;
      first_iot_pulse = 0;
      read_status_instruction = 0;
      device_select_lines = 6'h0;
      subdevice_select_lines = 2'h0;
      count_address = 15'h0;
      api_select = 0;
      regs_addr = 16'h0;
      regs_wdata = 32'h0;
      regs_write = 0;
      regs_read = 0;
      gdly = 4'd1;
      repeat (4) @(posedge core_clk);
      nrst <= 1;
      t_reset;
      t_count;
      t_flag;
      t_pi;
      t_chain;
      wrap_up;
   end
endmodule
